// ### logic/iarc_pkg.sv
// Purpose: Shared constants and types for the inertial sensor config slice
// Assumes: Byte-wide register port driven by the serial front end
// Notes: Offsets are the byte addresses seen on that port
package iarc_pkg;
	// Register offsets
	localparam logic [7:0] OFS_GYRO_AXIS_SIGN_ORIENT = 8'h0b;
	localparam logic [7:0] OFS_FIRST_PAD_EVENT_ROUTE = 8'h0d;
	localparam logic [7:0] OFS_SECOND_PAD_EVENT_ROUTE = 8'h0e;
	localparam logic [7:0] OFS_DEVICE_IDENTIFICATION = 8'h0f;
	localparam logic [7:0] OFS_ACCEL_RATE_SCALE_BW = 8'h10;
	// Values after reset
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] RST_ORIENT = 3'h0;
	// Field positions in the sign and orientation register
	localparam int POS_PITCH_NEG = 5;
	localparam int POS_ROLL_NEG = 4;
	localparam int POS_YAW_NEG = 3;
	// Field positions in the accelerometer control register
	localparam int POS_RATE_LSB = 4;
	localparam int POS_RANGE_LSB = 2;
	localparam int POS_BW_LSB = 0;
	// Orientation codes
	localparam logic [2:0] ORI_XYZ = 3'h0;
	localparam logic [2:0] ORI_XZY = 3'h1;
	localparam logic [2:0] ORI_YXZ = 3'h2;
	localparam logic [2:0] ORI_YZX = 3'h3;
	localparam logic [2:0] ORI_ZXY = 3'h4;
	localparam logic [2:0] ORI_ZYX = 3'h5;
	// Accelerometer rate codes
	localparam logic [3:0] ODR_OFF = 4'h0;
	localparam logic [3:0] ODR_52 = 4'h3;
	localparam logic [3:0] ODR_104 = 4'h4;
	localparam logic [3:0] ODR_208 = 4'h5;
	localparam logic [3:0] ODR_416 = 4'h6;
	localparam logic [3:0] ODR_1K66 = 4'h8;
	localparam logic [3:0] ODR_3K33 = 4'h9;
	localparam logic [3:0] ODR_6K66 = 4'ha;
	// Anti-aliasing bandwidth codes
	localparam logic [1:0] BW_400 = 2'h0;
	localparam logic [1:0] BW_200 = 2'h1;
	localparam logic [1:0] BW_100 = 2'h2;
	localparam logic [1:0] BW_50 = 2'h3;
	// Full scale codes as stored in the register
	localparam logic [1:0] FS_2G = 2'h0;
	localparam logic [1:0] FS_16G = 2'h1;
	localparam logic [1:0] FS_4G = 2'h2;
	localparam logic [1:0] FS_8G = 2'h3;

	// Accelerometer power mode
	typedef enum logic [3:0] {
		PM_POWER_DOWN = 4'h1,
		PM_LOW_POWER = 4'h2,
		PM_NORMAL = 4'h4,
		PM_HIGH_PERF = 4'h8
	} iarc_pmode_e;

	// Full scale in g, one-hot
	typedef enum logic [3:0] {
		RNG_2G = 4'h1,
		RNG_4G = 4'h2,
		RNG_8G = 4'h4,
		RNG_16G = 4'h8
	} iarc_range_e;

	// Event sources offered to the first pad, msb first
	typedef struct packed {
		logic step;
		logic sigmotion;
		logic queue_full;
		logic queue_overrun;
		logic queue_level;
		logic boot_status;
		logic rate_ready;
		logic accel_ready;
	} iarc_pad_a_ev_s;

	// Event sources offered to the second pad, msb first
	typedef struct packed {
		logic step_interval;
		logic stepcount_wrap;
		logic queue_full;
		logic queue_overrun;
		logic queue_level;
		logic thermal_ready;
		logic rate_ready;
		logic accel_ready;
	} iarc_pad_b_ev_s;

	// Three angular rate samples
	typedef struct packed {
		logic signed [15:0] a0;
		logic signed [15:0] a1;
		logic signed [15:0] a2;
	} iarc_axes_s;

	// Accelerometer operating point
	typedef struct packed {
		iarc_pmode_e pmode;
		logic [3:0] rate;
		iarc_range_e range;
		logic aa_bypass;
		logic [1:0] aa_bw;
	} iarc_accel_cfg_s;
endpackage : iarc_pkg

// ### logic/iarc_top.sv
// Purpose: Axis remap, interrupt routing, identity and accel config decode
// Assumes: Register port pulses come from the serial front end, synchronous
// Notes: All outputs are registered, one cycle behind their cause
`timescale 1ns/1ps
module iarc_top import iarc_pkg::*; #(
	parameter logic [7:0] ID_CODE = 8'h5a // Arbitrary identity value
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// Register port from the serial front end
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	output logic REG_RVALID,
	// Bits held in neighbouring control registers
	input wire logic ACCEL_HIPERF_DISABLE,
	input wire logic ACCEL_BW_MANUAL,
	// Event sources
	input iarc_pad_a_ev_s PAD_A_EVENTS,
	input iarc_pad_b_ev_s PAD_B_EVENTS,
	// Interrupt pads
	output logic FIRST_IRQ_PAD,
	output logic SECOND_IRQ_PAD,
	// Angular rate path
	input iarc_axes_s GYRO_RAW_XYZ,
	output iarc_axes_s GYRO_PITCH_ROLL_YAW,
	// Accelerometer operating point
	output iarc_accel_cfg_s ACCEL_CFG
);

	// Two's complement negate, wraps at the most negative value
	function automatic logic signed [15:0] iarc_signed(input logic signed [15:0] v,
		input logic neg);
		iarc_signed = neg ? 16'(-v) : v;
	endfunction : iarc_signed

	logic pitch_rate_negate_q;
	logic roll_rate_negate_q;
	logic yaw_rate_negate_q;
	logic [2:0] orient_q;
	logic [7:0] first_pad_event_route_q;
	logic [7:0] second_pad_event_route_q;
	logic [3:0] accel_rate_sel_q;
	logic [1:0] accel_range_sel_q;
	logic [1:0] accel_aa_bw_sel_q;
	logic [7:0] rdata_d;
	logic sel_orient;
	logic sel_route_a;
	logic sel_route_b;
	logic sel_accel;
	iarc_axes_s mapped_d;
	iarc_accel_cfg_s accel_d;

	// Address decode
	always_comb begin
		sel_orient = 1'b0;
		sel_route_a = 1'b0;
		sel_route_b = 1'b0;
		sel_accel = 1'b0;
		if (REG_ADDR == OFS_GYRO_AXIS_SIGN_ORIENT) begin
			sel_orient = 1'b1;
		end else if (REG_ADDR == OFS_FIRST_PAD_EVENT_ROUTE) begin
			sel_route_a = 1'b1;
		end else if (REG_ADDR == OFS_SECOND_PAD_EVENT_ROUTE) begin
			sel_route_b = 1'b1;
		end else if (REG_ADDR == OFS_ACCEL_RATE_SCALE_BW) begin
			sel_accel = 1'b1;
		end
	end

	// Sign and orientation register; top two bits are not stored
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pitch_rate_negate_q <= 1'b0;
			roll_rate_negate_q <= 1'b0;
			yaw_rate_negate_q <= 1'b0;
			orient_q <= RST_ORIENT;
		end else if (REG_WR && sel_orient) begin
			pitch_rate_negate_q <= REG_WDATA[POS_PITCH_NEG];
			roll_rate_negate_q <= REG_WDATA[POS_ROLL_NEG];
			yaw_rate_negate_q <= REG_WDATA[POS_YAW_NEG];
			orient_q <= REG_WDATA[2:0];
		end
	end

	// First pad routing register
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			first_pad_event_route_q <= RST_BYTE;
		end else if (REG_WR && sel_route_a) begin
			first_pad_event_route_q <= REG_WDATA;
		end
	end

	// Second pad routing register
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			second_pad_event_route_q <= RST_BYTE;
		end else if (REG_WR && sel_route_b) begin
			second_pad_event_route_q <= REG_WDATA;
		end
	end

	// Accelerometer rate, range and bandwidth register
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			accel_rate_sel_q <= ODR_OFF;
			accel_range_sel_q <= FS_2G;
			accel_aa_bw_sel_q <= BW_400;
		end else if (REG_WR && sel_accel) begin
			accel_rate_sel_q <= REG_WDATA[POS_RATE_LSB +: 4];
			accel_range_sel_q <= REG_WDATA[POS_RANGE_LSB +: 2];
			accel_aa_bw_sel_q <= REG_WDATA[POS_BW_LSB +: 2];
		end
	end

	// Read mux; identity is a constant, unmapped addresses read zero
	always_comb begin
		rdata_d = RST_BYTE;
		if (sel_orient) begin
			rdata_d = {2'h0, pitch_rate_negate_q, roll_rate_negate_q, yaw_rate_negate_q,
				orient_q};
		end else if (sel_route_a) begin
			rdata_d = first_pad_event_route_q;
		end else if (sel_route_b) begin
			rdata_d = second_pad_event_route_q;
		end else if (REG_ADDR == OFS_DEVICE_IDENTIFICATION) begin
			rdata_d = ID_CODE;
		end else if (sel_accel) begin
			rdata_d = {accel_rate_sel_q, accel_range_sel_q, accel_aa_bw_sel_q};
		end
	end

	// Read data capture
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			REG_RDATA <= RST_BYTE;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
			if (REG_RD) begin
				REG_RDATA <= rdata_d;
			end
		end
	end

	// Interrupt pads: bitwise enable against packed sources, then OR
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			FIRST_IRQ_PAD <= 1'b0;
			SECOND_IRQ_PAD <= 1'b0;
		end else begin
			FIRST_IRQ_PAD <= |(first_pad_event_route_q & PAD_A_EVENTS);
			// Step interval source already carries the separately set timing
			SECOND_IRQ_PAD <= |(second_pad_event_route_q & PAD_B_EVENTS);
		end
	end

	// Axis assignment; undefined codes fall back to the default mapping
	always_comb begin
		mapped_d = GYRO_RAW_XYZ;
		case (orient_q)
			ORI_XYZ: mapped_d = GYRO_RAW_XYZ;
			ORI_XZY: mapped_d = {GYRO_RAW_XYZ.a0, GYRO_RAW_XYZ.a2, GYRO_RAW_XYZ.a1};
			ORI_YXZ: mapped_d = {GYRO_RAW_XYZ.a1, GYRO_RAW_XYZ.a0, GYRO_RAW_XYZ.a2};
			ORI_YZX: mapped_d = {GYRO_RAW_XYZ.a1, GYRO_RAW_XYZ.a2, GYRO_RAW_XYZ.a0};
			ORI_ZXY: mapped_d = {GYRO_RAW_XYZ.a2, GYRO_RAW_XYZ.a0, GYRO_RAW_XYZ.a1};
			ORI_ZYX: mapped_d = {GYRO_RAW_XYZ.a2, GYRO_RAW_XYZ.a1, GYRO_RAW_XYZ.a0};
			default: mapped_d = GYRO_RAW_XYZ;
		endcase
	end

	// Sign applied after assignment, per output axis
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			GYRO_PITCH_ROLL_YAW <= '0;
		end else begin
			GYRO_PITCH_ROLL_YAW.a0 <= iarc_signed(mapped_d.a0, pitch_rate_negate_q);
			GYRO_PITCH_ROLL_YAW.a1 <= iarc_signed(mapped_d.a1, roll_rate_negate_q);
			GYRO_PITCH_ROLL_YAW.a2 <= iarc_signed(mapped_d.a2, yaw_rate_negate_q);
		end
	end

	// Accelerometer mode, range and filter decode
	always_comb begin
		accel_d.rate = accel_rate_sel_q;
		accel_d.pmode = PM_HIGH_PERF;
		accel_d.aa_bypass = 1'b0;
		accel_d.aa_bw = BW_50;
		// Codes above ODR_6K66 behave as power-down
		if (accel_rate_sel_q == ODR_OFF || accel_rate_sel_q > ODR_6K66) begin
			accel_d.rate = ODR_OFF;
			accel_d.pmode = PM_POWER_DOWN;
		end else if (ACCEL_HIPERF_DISABLE && accel_rate_sel_q <= ODR_52) begin
			accel_d.pmode = PM_LOW_POWER;
		end else if (ACCEL_HIPERF_DISABLE && accel_rate_sel_q <= ODR_208) begin
			accel_d.pmode = PM_NORMAL;
		end
		// Filter only in high performance below the two top rates
		if (accel_d.pmode != PM_HIGH_PERF || accel_rate_sel_q >= ODR_3K33) begin
			accel_d.aa_bypass = 1'b1;
		end
		if (ACCEL_BW_MANUAL) begin
			accel_d.aa_bw = accel_aa_bw_sel_q;
		end else if (accel_rate_sel_q >= ODR_1K66 - 4'h1) begin
			accel_d.aa_bw = BW_400;
		end else if (accel_rate_sel_q == ODR_416) begin
			accel_d.aa_bw = BW_200;
		end else if (accel_rate_sel_q == ODR_208) begin
			accel_d.aa_bw = BW_100;
		end else begin
			accel_d.aa_bw = BW_50;
		end
		case (accel_range_sel_q)
			FS_2G: accel_d.range = RNG_2G;
			FS_16G: accel_d.range = RNG_16G;
			FS_4G: accel_d.range = RNG_4G;
			FS_8G: accel_d.range = RNG_8G;
			default: accel_d.range = RNG_2G;
		endcase
	end

	// Registered accelerometer operating point
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ACCEL_CFG <= '{pmode: PM_POWER_DOWN, rate: ODR_OFF, range: RNG_2G,
				aa_bypass: 1'b1, aa_bw: BW_50};
		end else begin
			ACCEL_CFG <= accel_d;
		end
	end

endmodule : iarc_top

// ### dv/iarc_monitor.sv
// Purpose: Port-level property checks for the config slice
// Assumes: One clock, synchronous active high reset
// Notes: Register contents are inferred from port behaviour only
`timescale 1ns/1ps
module iarc_monitor import iarc_pkg::*; #(
	parameter logic [7:0] ID_CODE = 8'h5a // Arbitrary identity value
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic REG_RVALID,
	// Mode bits
	input wire logic ACCEL_HIPERF_DISABLE,
	input wire logic ACCEL_BW_MANUAL,
	// Events and pads
	input iarc_pad_a_ev_s PAD_A_EVENTS,
	input iarc_pad_b_ev_s PAD_B_EVENTS,
	input wire logic FIRST_IRQ_PAD,
	input wire logic SECOND_IRQ_PAD,
	// Accelerometer decode
	input iarc_accel_cfg_s ACCEL_CFG
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	// Bandwidth the rate alone should give
	logic [1:0] auto_bw;
	assign auto_bw = (ACCEL_CFG.rate >= 4'h7) ? BW_400 : (ACCEL_CFG.rate == 4'h6) ? BW_200 :
		(ACCEL_CFG.rate == 4'h5) ? BW_100 : BW_50;
	a_read_answer: assert property (REG_RD |=> REG_RVALID)
		else $error("read not answered next cycle");
	a_read_quiet: assert property (!REG_RD |=> !REG_RVALID)
		else $error("answer without read");
	a_id_value: assert property (REG_RD && REG_ADDR == 8'h0f |=> REG_RDATA == ID_CODE)
		else $error("identity read wrong");
	a_pad_a_idle: assert property (PAD_A_EVENTS == '0 |=> !FIRST_IRQ_PAD)
		else $error("first pad high with no event");
	a_pad_b_idle: assert property (PAD_B_EVENTS == '0 |=> !SECOND_IRQ_PAD)
		else $error("second pad high with no event");
	a_rate_off: assert property (ACCEL_CFG.rate == 4'h0 |-> ACCEL_CFG.pmode == PM_POWER_DOWN)
		else $error("rate off but powered");
	a_hiperf_all: assert property (ACCEL_CFG.rate != 4'h0 && !$past(ACCEL_HIPERF_DISABLE)
		|-> ACCEL_CFG.pmode == PM_HIGH_PERF)
		else $error("mode not high performance");
	a_filter_skip: assert property (ACCEL_CFG.rate >= 4'h9 || ACCEL_CFG.pmode != PM_HIGH_PERF
		|-> ACCEL_CFG.aa_bypass)
		else $error("filter not bypassed");
	a_auto_bw: assert property (!ACCEL_CFG.aa_bypass && !$past(ACCEL_BW_MANUAL)
		|-> ACCEL_CFG.aa_bw == auto_bw)
		else $error("automatic bandwidth wrong");
	// Main scenarios reached
	c_pad_a: cover property (FIRST_IRQ_PAD);
	c_pad_b: cover property (SECOND_IRQ_PAD);
	c_low: cover property (ACCEL_CFG.pmode == PM_LOW_POWER);
endmodule : iarc_monitor

// ### dv/iarc_host.sv
// Purpose: Host model driving the register port
// Assumes: Requests change only at the falling edge
// Notes: Write data is inverted once released
`timescale 1ns/1ps
module iarc_host import iarc_pkg::*; (
	// Clock
	input wire logic CLOCK,
	// Register port toward the device
	output logic [7:0] REG_ADDR = 8'h00,
	output logic REG_WR = 1'b0,
	output logic [7:0] REG_WDATA = 8'h00,
	output logic REG_RD = 1'b0,
	input wire logic [7:0] REG_RDATA,
	input wire logic REG_RVALID
);
	// One byte write, top bits of sign register kept clear
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge CLOCK);
		REG_ADDR = a;
		REG_WDATA = (a == OFS_GYRO_AXIS_SIGN_ORIENT) ? (d & 8'h3f) : d;
		REG_WR = 1'b1;
		@(negedge CLOCK);
		REG_WR = 1'b0;
		REG_WDATA = ~REG_WDATA;
	endtask : wr
	// One byte read, answer taken the cycle after
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge CLOCK);
		REG_ADDR = a;
		REG_RD = 1'b1;
		@(negedge CLOCK);
		REG_RD = 1'b0;
		d = REG_RDATA;
		v = REG_RVALID;
	endtask : rd
endmodule : iarc_host

// ### dv/testbench.sv
// Purpose: Self-checking bench for the config slice
// Assumes: Inputs driven at the falling edge
// Notes: Outputs checked one falling edge after cause
`timescale 1ns/1ps
module testbench import iarc_pkg::*;;
	localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hpd = 1'b0;
	logic man = 1'b0;
	logic [7:0] addr, wdat, rdata;
	logic wr, rd, rvalid, pad_a, pad_b;
	iarc_pad_a_ev_s ev_a = '0;
	iarc_pad_b_ev_s ev_b = '0;
	iarc_axes_s raw = '0;
	iarc_axes_s gyro;
	iarc_accel_cfg_s cfg;
	int err_total = 0;
	int checks_done = 0;
	// Clock at 20 MHz
	always #25 clk = ~clk;
	iarc_top #(.ID_CODE(ID)) uut (.CLOCK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr),
		.REG_WDATA(wdat), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
		.ACCEL_HIPERF_DISABLE(hpd), .ACCEL_BW_MANUAL(man), .PAD_A_EVENTS(ev_a),
		.PAD_B_EVENTS(ev_b), .FIRST_IRQ_PAD(pad_a), .SECOND_IRQ_PAD(pad_b),
		.GYRO_RAW_XYZ(raw), .GYRO_PITCH_ROLL_YAW(gyro), .ACCEL_CFG(cfg));
	iarc_host host (.CLOCK(clk), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdat), .REG_RD(rd),
		.REG_RDATA(rdata), .REG_RVALID(rvalid));
	// Compare and count
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Read one register and compare
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic v;
		host.rd(a, d, v);
		chk("read valid", 1'b1, v);
		chk("read data", exp, d);
	endtask : rchk
	// Expected remapped and signed rates
	function automatic iarc_axes_s gexp(iarc_axes_s r, logic [2:0] o, logic [2:0] s);
		logic [15:0] x[3] = '{r.a0, r.a1, r.a2};
		int pt[6] = '{0, 0, 1, 1, 2, 2};
		int rl[6] = '{1, 2, 0, 2, 0, 1};
		int yw[6] = '{2, 1, 2, 0, 1, 0};
		iarc_axes_s e;
		e.a0 = s[2] ? -x[pt[o]] : x[pt[o]];
		e.a1 = s[1] ? -x[rl[o]] : x[rl[o]];
		e.a2 = s[0] ? -x[yw[o]] : x[yw[o]];
		return e;
	endfunction : gexp
	// Expected accelerometer operating point
	function automatic iarc_accel_cfg_s aexp(logic [7:0] v, logic h, logic m);
		iarc_range_e rg[4] = '{RNG_2G, RNG_16G, RNG_4G, RNG_8G};
		iarc_accel_cfg_s e;
		e.rate = v[7:4];
		e.pmode = (v[7:4] == 4'h0) ? PM_POWER_DOWN : (h && v[7:4] <= 4'h3) ? PM_LOW_POWER :
			(h && v[7:4] <= 4'h5) ? PM_NORMAL : PM_HIGH_PERF;
		e.range = rg[v[3:2]];
		e.aa_bypass = (e.pmode != PM_HIGH_PERF) || (v[7:4] >= 4'h9);
		e.aa_bw = m ? v[1:0] : (v[7:4] >= 4'h7) ? BW_400 : (v[7:4] == 4'h6) ? BW_200 :
			(v[7:4] == 4'h5) ? BW_100 : BW_50;
		return e;
	endfunction : aexp
	// Print counts and verdict, then stop
	task automatic end_sim();
		$display("Checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim
	// Watchdog against a hang
	initial begin
		#500000;
		err_total++;
		end_sim();
	end
	// Main sequence
	initial begin
		logic [7:0] r8, s8;
		iarc_accel_cfg_s e;
		void'($urandom(61));
		repeat (6) @(negedge clk);
		rst = 1'b0;
		chk("reset cfg", {PM_POWER_DOWN, 4'h0, RNG_2G, 1'b1, BW_50}, cfg);
		foreach (s8[i]) rchk(8'h0b + 8'(i), (i == 4) ? ID : 8'h00);
		host.wr(OFS_DEVICE_IDENTIFICATION, ~ID);
		rchk(OFS_DEVICE_IDENTIFICATION, ID);
		for (int i = 0; i < 48; i++) begin
			r8 = (i < 8) ? 8'h01 << i : 8'($urandom);
			s8 = (i < 8) ? 8'h01 << i : 8'($urandom);
			host.wr(OFS_FIRST_PAD_EVENT_ROUTE, r8);
			host.wr(OFS_SECOND_PAD_EVENT_ROUTE, s8);
			ev_a = (i < 8) ? ~r8 : 8'($urandom);
			ev_b = (i < 8) ? s8 : 8'($urandom);
			@(negedge clk);
			chk("first pad", |(r8 & ev_a), pad_a);
			chk("second pad", |(s8 & ev_b), pad_b);
			rchk(OFS_SECOND_PAD_EVENT_ROUTE, s8);
		end
		for (int k = 0; k < 24; k++) begin
			r8 = {2'b00, 3'($urandom), 3'(k % 6)};
			host.wr(OFS_GYRO_AXIS_SIGN_ORIENT, r8);
			raw = 48'({$urandom, $urandom});
			@(negedge clk);
			chk("gyro", gexp(raw, r8[2:0], r8[5:3]), gyro);
			rchk(OFS_GYRO_AXIS_SIGN_ORIENT, r8);
		end
		for (int k = 0; k < 44; k++) begin
			r8 = {4'(k % 11), 4'($urandom)};
			host.wr(OFS_ACCEL_RATE_SCALE_BW, r8);
			hpd = 1'((k / 11) % 2);
			man = 1'(k / 22);
			@(negedge clk);
			e = aexp(r8, hpd, man);
			chk("accel cfg", e[14:2], cfg[14:2]);
			if (!e.aa_bypass) chk("accel bw", e.aa_bw, cfg.aa_bw);
		end
		end_sim();
	end
endmodule : testbench
bind iarc_top iarc_monitor #(.ID_CODE(ID_CODE)) mon (.CLOCK(CLOCK), .RST(RST),
	.REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
	.ACCEL_HIPERF_DISABLE(ACCEL_HIPERF_DISABLE), .ACCEL_BW_MANUAL(ACCEL_BW_MANUAL),
	.PAD_A_EVENTS(PAD_A_EVENTS), .PAD_B_EVENTS(PAD_B_EVENTS), .FIRST_IRQ_PAD(FIRST_IRQ_PAD),
	.SECOND_IRQ_PAD(SECOND_IRQ_PAD), .ACCEL_CFG(ACCEL_CFG));
